// [src/rx_line_mon_consts.vh]
/*
 * constants for the receive line code error and signal loss monitor:
 * register indices, field positions, thresholds and timing counts.
 * assumes inclusion by bare name from the monitor module.
 */
`ifndef RX_LINE_MON_CONSTS_VH
`define RX_LINE_MON_CONSTS_VH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define IDX_ONES_INSERT_CTRL 10'h020
`define IDX_RX_CONFIG_ZERO 10'h028
`define IDX_RX_CONFIG_ONE 10'h029
`define IDX_MAINT_CTRL_ONE 10'h02c
`define IDX_MAINT_CTRL_TWO 10'h031
`define IDX_IRQ_ENABLE_ZERO 10'h033
`define IDX_IRQ_ENABLE_ONE 10'h034
`define IDX_IRQ_EDGE_SELECT 10'h035
`define IDX_LINE_STATE_ZERO 10'h036
`define IDX_IRQ_FLAGS_ZERO 10'h03a
`define IDX_IRQ_FLAGS_ONE 10'h03b
`define IDX_ZERO_ERR_COUNT_HIGH 10'h03c
`define IDX_ZERO_ERR_COUNT_LOW 10'h03d

// ***************************************************************
// field positions
// ***************************************************************
`define BIT_ONES_INSERT 0
`define BIT_LINE_CODE_SEL 0
`define BIT_E1_MODE 1
`define BIT_LONG_HAUL 5
`define BIT_CRITERIA_SEL 0
`define BIT_STD_SEL 0
`define LSB_COUNT_SEL 1
`define BIT_REPORT_MODE 3
`define BIT_REPORT_TRIG 4
`define BIT_VIOL 0
`define BIT_EXZ 1
`define BIT_OVF 2
`define COUNT_SEL_ON 2'h1

// ***************************************************************
// reset values
// ***************************************************************
`define RST_BYTE 8'h00
`define RST_THRESHOLD 5'h00

// ***************************************************************
// excess zero limits (run longer than the limit is an error)
// ***************************************************************
`define EXZ_FCC_AMI 8'h50
`define EXZ_B8ZS 8'h07
`define EXZ_HDB3 8'h03

// ***************************************************************
// signal loss declare runs and clear windows, in bit intervals
// ***************************************************************
`define LOS_T1_ANSI_RUN 12'h0af
`define LOS_T1_I431_RUN 12'h608
`define LOS_E1_G775_RUN 12'h020
`define LOS_E1_I431_RUN 12'h800
`define WIN_T1_SIZE 8'h80
`define WIN_T1_MARKS 8'h10
`define WIN_T1_ZEROS 8'h64
`define WIN_E1_SIZE 8'h20
`define WIN_E1_MARKS 8'h04
`define WIN_E1_ZEROS 8'h10

// ***************************************************************
// timing
// ***************************************************************
// one second of the 20 mhz ref_clk, sized to the 25-bit period counter
`define REPORT_CYCLES 25'h1312d00

`endif

// [src/rx_line_mon.v]
/*
 * receive line code error and signal loss monitor: bipolar, hdb3 and
 * b8zs violation checks, excess zero detection and a 16-bit counter
 * with manual or periodic reporting, signal loss declare and clear,
 * all ones insertion, status flags, interrupt and an apb slave.
 * assumes the analog front end gives per bit interval a strobe, the
 * pulse polarity and two amplitude indications, all asynchronous to
 * ref_clk and each bit interval lasting several ref_clk periods.
 */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "rx_line_mon_consts.vh"

module rx_line_mon #(
   parameter [7:0] EXZ_ANSI_AMI = 8'h0f,
   parameter [24:0] REPORT_CYCLES = `REPORT_CYCLES
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // front end, asynchronous
   input wire bit_strobe,
   input wire pulse_pos,
   input wire pulse_neg,
   input wire amp_below,
   input wire amp_above,
   // front end control
   output reg [4:0] signal_loss_threshold,
   output reg long_haul,
   // downstream
   output reg rx_data,
   output reg rx_data_valid,
   output reg bpv_event,
   output reg signal_loss_state,
   output reg irq
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   reg [4:0] s1_q;
   reg [4:0] s2_q;
   reg strobe_prev_q;
   reg ones_ins_q;
   reg line_code_select;
   reg e1_mode_q;
   reg signal_loss_criteria_sel;
   reg zero_err_standard_select;
   reg [1:0] zero_err_count_select;
   reg report_mode_sel;
   reg report_trigger;
   reg signal_loss_irq_en;
   reg violation_irq_en;
   reg excess_zero_irq_en;
   reg counter_overflow_irq_en;
   reg signal_loss_edge_sel;
   reg signal_loss_flag;
   reg violation_flag;
   reg excess_zero_flag;
   reg counter_overflow_flag;
   reg [15:0] zero_err_count_q;
   reg [15:0] report_q;
   reg [24:0] sec_cnt_q;
   reg have_mark_q;
   reg last_pol_q;
   reg last_vpol_q;
   reg [7:0] zrun_q;
   reg [2:0] b8_dist_q;
   reg [11:0] low_run_q;
   reg [7:0] win_cnt_q;
   reg [7:0] win_marks_q;
   reg [7:0] win_zrun_q;
   reg win_fail_q;
   reg [31:0] rdata_d;
   reg mapped_d;
   reg [7:0] exz_limit_d;
   reg [11:0] run_limit_d;
   reg [7:0] win_size_d;
   reg [7:0] win_min_d;
   reg [7:0] win_zmax_d;

   wire tick;
   wire mark;
   wire pol;
   wire amp_lo;
   wire amp_hi;
   wire hdb3_mode;
   wire b8zs_mode;
   wire ami_mode;
   wire viol;
   wire bpv;
   wire cv;
   wire b8_first_ok;
   wire b8_second_ok;
   wire hdb3_ok;
   wire excess_zeros;
   wire cnt_en;
   wire sec_tick;
   wire trig_rise;
   wire transfer;
   wire wr;
   wire [9:0] idx;
   wire los_set;
   wire los_clr;
   wire los_next;
   wire [7:0] marks_n;
   wire [7:0] zrun_win_n;
   wire fail_n;
   wire win_end;

   // ***************************************************************
   // front end synchroniser and bit strobe edge
   // ***************************************************************
   // two flops on every asynchronous pin; only s2 feeds logic
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= 5'h00;
         s2_q <= 5'h00;
         strobe_prev_q <= 1'b0;
      end else begin
         s1_q <= {bit_strobe, pulse_pos, pulse_neg, amp_below, amp_above};
         s2_q <= s1_q;
         strobe_prev_q <= s2_q[4];
      end
   end

   // polarity and amplitude are stable when the strobe rises
   assign tick = s2_q[4] & ~strobe_prev_q;
   assign mark = s2_q[3] | s2_q[2];
   assign pol = s2_q[3];
   assign amp_lo = s2_q[1];
   assign amp_hi = s2_q[0];

   // ***************************************************************
   // line code checks
   // ***************************************************************
   assign hdb3_mode = line_code_select & e1_mode_q;
   assign b8zs_mode = line_code_select & ~e1_mode_q;
   assign ami_mode = ~line_code_select;
   assign viol = tick & mark & have_mark_q & (pol == last_pol_q);
   assign bpv = ami_mode & viol;
   // b8zs pattern 000vb0vb: first v after three zeros, second 3 bits on
   assign b8_first_ok = (zrun_q == 8'h03);
   assign b8_second_ok = (b8_dist_q == 3'h3) & (zrun_q == 8'h01);
   // hdb3 v follows 000 or b00 and alternates with the previous v
   assign hdb3_ok = (zrun_q >= 8'h02) & (pol != last_vpol_q);
   assign cv = viol & ((b8zs_mode & ~b8_first_ok & ~b8_second_ok)
      | (hdb3_mode & ~hdb3_ok));

   // excess zero limit by code and standard
   always @* begin
      if (hdb3_mode)
         exz_limit_d = `EXZ_HDB3;
      else if (b8zs_mode)
         exz_limit_d = `EXZ_B8ZS;
      else if (zero_err_standard_select)
         exz_limit_d = `EXZ_FCC_AMI;
      else
         exz_limit_d = EXZ_ANSI_AMI;
   end

   // fires once, on the zero that makes the run exceed the limit
   assign excess_zeros = tick & ~mark & (zrun_q == exz_limit_d);

   // polarity, zero run and b8zs distance tracking
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         have_mark_q <= 1'b0;
         last_pol_q <= 1'b0;
         last_vpol_q <= 1'b0;
         zrun_q <= 8'h00;
         b8_dist_q <= 3'h0;
      end else if (tick) begin
         if (mark) begin
            have_mark_q <= 1'b1;
            last_pol_q <= pol;
            zrun_q <= 8'h00;
         end else if (zrun_q != 8'hff) begin
            zrun_q <= zrun_q + 8'h01;
         end
         if (viol)
            last_vpol_q <= pol;
         if (viol & b8_first_ok)
            b8_dist_q <= 3'h1;
         else if (b8_dist_q != 3'h0 && b8_dist_q != 3'h7)
            b8_dist_q <= b8_dist_q + 3'h1;
      end
   end

   // ***************************************************************
   // excess zero counter and reporting
   // ***************************************************************
   assign cnt_en = excess_zeros & (zero_err_count_select == `COUNT_SEL_ON);
   assign sec_tick = (sec_cnt_q == REPORT_CYCLES - 25'h1);
   assign trig_rise = wr & (idx == `IDX_MAINT_CTRL_TWO)
      & pwdata[`BIT_REPORT_TRIG] & ~report_trigger;
   assign transfer = report_mode_sel ? sec_tick : trig_rise;

   // a copy clears the counter but keeps an event of the same cycle
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         zero_err_count_q <= 16'h0000;
         report_q <= 16'h0000;
         sec_cnt_q <= 25'h0000000;
      end else begin
         sec_cnt_q <= sec_tick ? 25'h0000000 : sec_cnt_q + 25'h0000001;
         if (transfer) begin
            report_q <= zero_err_count_q;
            zero_err_count_q <= {15'h0000, cnt_en};
         end else if (cnt_en && zero_err_count_q != 16'hffff) begin
            zero_err_count_q <= zero_err_count_q + 16'h0001;
         end
      end
   end

   // ***************************************************************
   // signal loss declare and clear
   // ***************************************************************
   always @* begin
      if (e1_mode_q) begin
         run_limit_d = signal_loss_criteria_sel ? `LOS_E1_I431_RUN
            : `LOS_E1_G775_RUN;
         win_size_d = `WIN_E1_SIZE;
         win_min_d = `WIN_E1_MARKS;
         win_zmax_d = `WIN_E1_ZEROS;
      end else begin
         run_limit_d = signal_loss_criteria_sel ? `LOS_T1_I431_RUN
            : `LOS_T1_ANSI_RUN;
         win_size_d = `WIN_T1_SIZE;
         win_min_d = `WIN_T1_MARKS;
         win_zmax_d = `WIN_T1_ZEROS;
      end
   end

   // only marks above the clear threshold count toward density
   assign marks_n = win_marks_q + {7'h00, mark & amp_hi};
   assign zrun_win_n = mark ? 8'h00 : win_zrun_q + 8'h01;
   assign fail_n = win_fail_q | (zrun_win_n >= win_zmax_d);
   assign win_end = (win_cnt_q == win_size_d - 8'h01);
   assign los_set = tick & ~signal_loss_state & amp_lo
      & (low_run_q == run_limit_d - 12'h001);
   assign los_clr = tick & signal_loss_state & win_end
      & ~fail_n & (marks_n >= win_min_d);
   assign los_next = (signal_loss_state | los_set) & ~los_clr;

   // a failing block is thrown away whole and the next one begins
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         signal_loss_state <= 1'b0;
         low_run_q <= 12'h000;
         win_cnt_q <= 8'h00;
         win_marks_q <= 8'h00;
         win_zrun_q <= 8'h00;
         win_fail_q <= 1'b0;
      end else begin
         signal_loss_state <= los_next;
         if (tick) begin
            if (amp_lo && low_run_q != 12'hfff)
               low_run_q <= low_run_q + 12'h001;
            else if (!amp_lo)
               low_run_q <= 12'h000;
            if (!signal_loss_state || win_end) begin
               win_cnt_q <= 8'h00;
               win_marks_q <= 8'h00;
               win_zrun_q <= 8'h00;
               win_fail_q <= 1'b0;
            end else begin
               win_cnt_q <= win_cnt_q + 8'h01;
               win_marks_q <= marks_n;
               win_zrun_q <= zrun_win_n;
               win_fail_q <= fail_n;
            end
         end
      end
   end

   // ***************************************************************
   // data out, events, status flags, interrupt
   // ***************************************************************
   assign wr = psel & penable & pwrite & ~pready;
   assign idx = paddr[11:2];

   // hardware set wins over a write-one-to-clear in the same cycle
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data <= 1'b0;
         rx_data_valid <= 1'b0;
         bpv_event <= 1'b0;
         signal_loss_flag <= 1'b0;
         violation_flag <= 1'b0;
         excess_zero_flag <= 1'b0;
         counter_overflow_flag <= 1'b0;
         irq <= 1'b0;
      end else begin
         rx_data_valid <= tick;
         if (tick)
            rx_data <= mark | (signal_loss_state & ones_ins_q);
         bpv_event <= bpv;
         if (wr && idx == `IDX_IRQ_FLAGS_ZERO && pwdata[0])
            signal_loss_flag <= 1'b0;
         if (wr && idx == `IDX_IRQ_FLAGS_ONE) begin
            if (pwdata[`BIT_VIOL])
               violation_flag <= 1'b0;
            if (pwdata[`BIT_EXZ])
               excess_zero_flag <= 1'b0;
            if (pwdata[`BIT_OVF])
               counter_overflow_flag <= 1'b0;
         end
         if (los_next != signal_loss_state
             && (los_next || signal_loss_edge_sel))
            signal_loss_flag <= 1'b1;
         if (bpv | cv)
            violation_flag <= 1'b1;
         if (excess_zeros)
            excess_zero_flag <= 1'b1;
         if (cnt_en && !transfer && zero_err_count_q == 16'hffff)
            counter_overflow_flag <= 1'b1;
         irq <= (violation_flag & violation_irq_en)
            | (excess_zero_flag & excess_zero_irq_en)
            | (counter_overflow_flag & counter_overflow_irq_en)
            | (signal_loss_flag & signal_loss_irq_en);
      end
   end

   // ***************************************************************
   // apb registers
   // ***************************************************************
   // control writes land on the access cycle that raises pready
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ones_ins_q <= 1'b0;
         line_code_select <= 1'b0;
         e1_mode_q <= 1'b0;
         signal_loss_threshold <= `RST_THRESHOLD;
         long_haul <= 1'b0;
         signal_loss_criteria_sel <= 1'b0;
         zero_err_standard_select <= 1'b0;
         zero_err_count_select <= 2'h0;
         report_mode_sel <= 1'b0;
         report_trigger <= 1'b0;
         signal_loss_irq_en <= 1'b0;
         violation_irq_en <= 1'b0;
         excess_zero_irq_en <= 1'b0;
         counter_overflow_irq_en <= 1'b0;
         signal_loss_edge_sel <= 1'b0;
      end else if (wr) begin
         case (idx)
            `IDX_ONES_INSERT_CTRL: ones_ins_q <= pwdata[`BIT_ONES_INSERT];
            `IDX_RX_CONFIG_ZERO: begin
               line_code_select <= pwdata[`BIT_LINE_CODE_SEL];
               e1_mode_q <= pwdata[`BIT_E1_MODE];
            end
            `IDX_RX_CONFIG_ONE: begin
               signal_loss_threshold <= pwdata[4:0];
               long_haul <= pwdata[`BIT_LONG_HAUL];
            end
            `IDX_MAINT_CTRL_ONE:
               signal_loss_criteria_sel <= pwdata[`BIT_CRITERIA_SEL];
            `IDX_MAINT_CTRL_TWO: begin
               zero_err_standard_select <= pwdata[`BIT_STD_SEL];
               zero_err_count_select <= pwdata[`LSB_COUNT_SEL +: 2];
               report_mode_sel <= pwdata[`BIT_REPORT_MODE];
               report_trigger <= pwdata[`BIT_REPORT_TRIG];
            end
            `IDX_IRQ_ENABLE_ZERO: signal_loss_irq_en <= pwdata[0];
            `IDX_IRQ_ENABLE_ONE: begin
               violation_irq_en <= pwdata[`BIT_VIOL];
               excess_zero_irq_en <= pwdata[`BIT_EXZ];
               counter_overflow_irq_en <= pwdata[`BIT_OVF];
            end
            `IDX_IRQ_EDGE_SELECT: signal_loss_edge_sel <= pwdata[0];
            default: ones_ins_q <= ones_ins_q;
         endcase
      end
   end

   // read mux; narrower registers sit in the low byte
   always @* begin
      rdata_d = 32'h00000000;
      mapped_d = 1'b1;
      case (idx)
         `IDX_ONES_INSERT_CTRL: rdata_d[0] = ones_ins_q;
         `IDX_RX_CONFIG_ZERO:
            rdata_d[1:0] = {e1_mode_q, line_code_select};
         `IDX_RX_CONFIG_ONE:
            rdata_d[5:0] = {long_haul, signal_loss_threshold};
         `IDX_MAINT_CTRL_ONE: rdata_d[0] = signal_loss_criteria_sel;
         `IDX_MAINT_CTRL_TWO:
            rdata_d[4:0] = {report_trigger, report_mode_sel,
               zero_err_count_select, zero_err_standard_select};
         `IDX_IRQ_ENABLE_ZERO: rdata_d[0] = signal_loss_irq_en;
         `IDX_IRQ_ENABLE_ONE:
            rdata_d[2:0] = {counter_overflow_irq_en, excess_zero_irq_en,
               violation_irq_en};
         `IDX_IRQ_EDGE_SELECT: rdata_d[0] = signal_loss_edge_sel;
         `IDX_LINE_STATE_ZERO: rdata_d[0] = signal_loss_state;
         `IDX_IRQ_FLAGS_ZERO: rdata_d[0] = signal_loss_flag;
         `IDX_IRQ_FLAGS_ONE:
            rdata_d[2:0] = {counter_overflow_flag, excess_zero_flag,
               violation_flag};
         `IDX_ZERO_ERR_COUNT_HIGH: rdata_d[7:0] = report_q[15:8];
         `IDX_ZERO_ERR_COUNT_LOW: rdata_d[7:0] = report_q[7:0];
         default: mapped_d = 1'b0;
      endcase
   end

   // one wait state: pready is high on the second access cycle
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped_d;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rdata_d
            : 32'h00000000;
      end
   end

endmodule // rx_line_mon

// [verification/rx_line_mon_props.sv]
/*
 * port assertions for the receive line monitor.
 * assumes a bind onto rx_line_mon and its single ref_clk domain.
 */
`timescale 1ns/1ps
module rx_line_mon_props (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   // line side
   input wire rx_data,
   input wire rx_data_valid,
   input wire bpv_event,
   input wire signal_loss_state,
   input wire [4:0] signal_loss_threshold
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // bus answers one cycle after the first access edge
   a_ready_answer: assert property (psel && penable && !pready |=> pready)
      else $error("no ready after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside ready");
   a_valid_pulse: assert property (rx_data_valid |=> !rx_data_valid)
      else $error("valid wider than one cycle");
   a_bpv_on_mark: assert property (
      bpv_event |-> rx_data_valid && rx_data)
      else $error("violation event off a mark");
   a_data_holds: assert property (!rx_data_valid |-> $stable(rx_data))
      else $error("data moved between bits");
   // loss state only moves as a bit is delivered
   a_loss_on_bit: assert property (
      $changed(signal_loss_state) |-> rx_data_valid)
      else $error("loss state moved off a bit");
   a_thresh_by_write: assert property (
      $changed(signal_loss_threshold) |-> $past(psel && penable && pwrite))
      else $error("threshold moved without a write");
endmodule // rx_line_mon_props

bind rx_line_mon rx_line_mon_props u_props (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .rx_data(rx_data), .rx_data_valid(rx_data_valid),
   .bpv_event(bpv_event), .signal_loss_state(signal_loss_state),
   .signal_loss_threshold(signal_loss_threshold));

// [verification/rx_front_end_model.sv]
/*
 * slicer and clock recovery model: one bit interval per send call.
 * assumes ref_clk is the monitor clock; levels settle before strobe.
 */
`timescale 1ns/1ps
module rx_front_end_model (
   // clock
   input wire ref_clk,
   // line indications
   output logic bit_strobe = 1'b0,
   output logic pulse_pos = 1'b0,
   output logic pulse_neg = 1'b0,
   output logic amp_below = 1'b0,
   output logic amp_above = 1'b0
);
   // levels lead the strobe by 3 clocks; once the strobe falls the
   // marks are no longer held, so show the inverse, not the old value
   task send(input logic p, input logic n, input logic b, input logic a);
      @(posedge ref_clk);
      {pulse_pos, pulse_neg, amp_below, amp_above} <= {p, n, b, a};
      repeat (3) @(posedge ref_clk);
      bit_strobe <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bit_strobe <= 1'b0;
      {pulse_pos, pulse_neg} <= ~{p, n};
      repeat (2) @(posedge ref_clk);
   endtask
endmodule // rx_front_end_model

// [verification/rx_line_mon_tb_top.sv]
/*
 * self-checking bench for the receive line monitor.
 * assumes the register header and the front end model are compiled.
 */
`timescale 1ns/1ps
`include "rx_line_mon_consts.vh"
`define check_eq(a, e) begin n_checks++; if ((a) !== (e)) begin \
   n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module rx_line_mon_tb_top;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic err;
   wire [31:0] prdata;
   wire [4:0] signal_loss_threshold;
   wire pready, pslverr, bit_strobe, pulse_pos, pulse_neg, amp_below;
   wire amp_above, long_haul, rx_data, rx_data_valid, bpv_event, irq;
   wire signal_loss_state;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_bpv = 0;
   int n_cyc = 0;

   rx_line_mon #(.EXZ_ANSI_AMI(8'h0f), .REPORT_CYCLES(25'h0000c8)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bit_strobe(bit_strobe), .pulse_pos(pulse_pos),
      .pulse_neg(pulse_neg), .amp_below(amp_below),
      .amp_above(amp_above), .signal_loss_threshold(signal_loss_threshold),
      .long_haul(long_haul), .rx_data(rx_data),
      .rx_data_valid(rx_data_valid), .bpv_event(bpv_event),
      .signal_loss_state(signal_loss_state), .irq(irq));
   rx_front_end_model fe (.ref_clk(ref_clk), .bit_strobe(bit_strobe),
      .pulse_pos(pulse_pos), .pulse_neg(pulse_neg),
      .amp_below(amp_below), .amp_above(amp_above));

   always #25 ref_clk = ~ref_clk;
   // event tally and hang guard; the run needs well under 20000 cycles
   always @(posedge ref_clk) begin
      n_cyc++;
      if (bpv_event === 1'b1) n_bpv++;
      if (n_cyc == 20000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end

   task tally_and_finish;
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // one apb transfer, held until ready is sampled high
   task apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge ref_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, idx, 2'b00, 24'h0, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      {err, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask

   task t_regs;
      apb(1, `IDX_RX_CONFIG_ONE, 8'h3f);
      `check_eq({long_haul, signal_loss_threshold}, 6'h3f)
      apb(0, `IDX_RX_CONFIG_ONE, 8'h00);
      `check_eq(rd, 32'h3f)
      apb(1, `IDX_ZERO_ERR_COUNT_LOW, 8'h5a);
      apb(0, `IDX_ZERO_ERR_COUNT_LOW, 8'h00);
      `check_eq(rd, 32'h0)
      apb(0, 10'h000, 8'h00);
      `check_eq({err, rd}, 33'h100000000)
   endtask

   task t_viol;
      apb(1, `IDX_IRQ_ENABLE_ONE, 8'h01);
      fe.send(1, 0, 0, 1);
      fe.send(1, 0, 0, 1);
      `check_eq(n_bpv, 1)
      `check_eq(irq, 1'b1)
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[0], 1'b1)
      apb(1, `IDX_IRQ_FLAGS_ONE, 8'h07);
      apb(1, `IDX_RX_CONFIG_ZERO, 8'h03);
      fe.send(0, 1, 0, 1);
      fe.send(0, 0, 0, 1);
      fe.send(0, 1, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[0], 1'b1)
      `check_eq(n_bpv, 1)
   endtask

   task t_exz;
      apb(1, `IDX_RX_CONFIG_ZERO, 8'h01);
      apb(1, `IDX_IRQ_FLAGS_ONE, 8'h07);
      apb(1, `IDX_MAINT_CTRL_TWO, 8'h02);
      fe.send(1, 0, 0, 1);
      repeat (7) fe.send(0, 0, 0, 1);
      fe.send(0, 1, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[1], 1'b0)
      repeat (8) fe.send(0, 0, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[1], 1'b1)
      apb(1, `IDX_MAINT_CTRL_TWO, 8'h12);
      apb(0, `IDX_ZERO_ERR_COUNT_LOW, 8'h00);
      `check_eq(rd, 32'h1)
      apb(0, `IDX_ZERO_ERR_COUNT_HIGH, 8'h00);
      `check_eq(rd, 32'h0)
      apb(1, `IDX_MAINT_CTRL_TWO, 8'h02);
      apb(1, `IDX_MAINT_CTRL_TWO, 8'h12);
      apb(0, `IDX_ZERO_ERR_COUNT_LOW, 8'h00);
      `check_eq(rd, 32'h0)
      // ami under ansi, then fcc, then automatic once per report period
      apb(1, `IDX_RX_CONFIG_ZERO, 8'h00);
      apb(1, `IDX_IRQ_FLAGS_ONE, 8'h07);
      fe.send(1, 0, 0, 1);
      repeat (15) fe.send(0, 0, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[1], 1'b0)
      fe.send(0, 0, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[1], 1'b1)
      apb(1, `IDX_MAINT_CTRL_TWO, 8'h03);
      apb(1, `IDX_IRQ_FLAGS_ONE, 8'h07);
      fe.send(0, 1, 0, 1);
      repeat (80) fe.send(0, 0, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[1], 1'b0)
      fe.send(0, 0, 0, 1);
      apb(0, `IDX_IRQ_FLAGS_ONE, 8'h00);
      `check_eq(rd[1], 1'b1)
      apb(1, `IDX_MAINT_CTRL_TWO, 8'h0b);
      for (int i = 0; i < 60 && rd == 32'h0; i++)
         apb(0, `IDX_ZERO_ERR_COUNT_LOW, 8'h00);
      `check_eq(rd, 32'h2)
   endtask

   // e1 with long_haul left set: declare after 32 low bits, clear on a good window
   task t_los;
      apb(1, `IDX_IRQ_ENABLE_ONE, 8'h00);
      apb(1, `IDX_RX_CONFIG_ZERO, 8'h02);
      apb(1, `IDX_ONES_INSERT_CTRL, 8'h01);
      apb(1, `IDX_IRQ_ENABLE_ZERO, 8'h01);
      repeat (31) fe.send(0, 0, 1, 0);
      `check_eq({signal_loss_state, irq}, 2'b00)
      fe.send(0, 0, 1, 0);
      `check_eq(signal_loss_state, 1'b1)
      `check_eq(irq, 1'b1)
      // the declaring bit is still raw; insertion starts on the next one
      fe.send(0, 0, 1, 0);
      `check_eq(rx_data, 1'b1)
      apb(1, `IDX_IRQ_FLAGS_ZERO, 8'h01);
      for (int i = 0; i < 32; i++) begin
         fe.send(i % 16 == 0, i % 16 == 8, 0, 1);
      end
      `check_eq(signal_loss_state, 1'b0)
      apb(0, `IDX_IRQ_FLAGS_ZERO, 8'h00);
      `check_eq(rd[0], 1'b0)
      // with any-change edge select the clearing also sets the flag
      apb(1, `IDX_IRQ_EDGE_SELECT, 8'h01);
      repeat (32) fe.send(0, 0, 1, 0);
      apb(1, `IDX_IRQ_FLAGS_ZERO, 8'h01);
      for (int i = 0; i < 32; i++) begin
         fe.send(i % 16 == 0, i % 16 == 8, 0, 1);
      end
      apb(0, `IDX_IRQ_FLAGS_ZERO, 8'h00);
      `check_eq({signal_loss_state, rd[0]}, 2'b01)
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_viol;
      t_exz;
      t_los;
      tally_and_finish;
   end
endmodule // rx_line_mon_tb_top
